// file: pir_params.svh
// constants for the power-management serial register port
`ifndef PIR_PARAMS_SVH
`define PIR_PARAMS_SVH
`define PIR_ADDR_OPT1 7'h09
`define PIR_ADDR_OPT2 7'h34
`define PIR_SUB_NULL 4'h0
`define PIR_SUB_SD1 4'h1
`define PIR_SUB_SD2 4'h2
`define PIR_SUB_SD3 4'h3
`define PIR_SUB_SD4 4'h4
`define PIR_SUB_UP 4'h5
`define PIR_SUB_UPDN 4'h6
`define PIR_SUB_LEDCFG 4'h7
`define PIR_SUB_LEDCUR 4'h8
`define PIR_SUB_ALARM 4'h9
`define PIR_SUB_RSTMASK 4'hA
`define PIR_SUB_IRQMASK 4'hB
`define PIR_SUB_LIVE 4'hC
`define PIR_SUB_LATCHED 4'hD
`define PIR_SUB_CLR 4'hF
`define PIR_NUM_CMD 11
`define PIR_RST_SD 8'h6F
`define PIR_RST_UP 8'h0F
`define PIR_RST_LEDCFG 8'h0F
`define PIR_RST_LEDCUR 8'h00
`define PIR_RST_ALARM 8'h00
`define PIR_RST_RSTMASK 8'hFF
`define PIR_RST_IRQMASK 8'h00
`define PIR_GLOBAL_RESET_BIT 7
`define PIR_SD_ENABLE_BIT 7
`define PIR_OFF_TIME_MS 1000
`define PIR_CLK_HZ 20000000
`define PIR_OFF_CYCLES ((`PIR_CLK_HZ / 1000) * `PIR_OFF_TIME_MS)
`endif

// file: pir_pkg.sv
// types for the power-management serial register port
package pir_pkg;
	typedef enum logic [2:0] {
		PIR_IDLE,
		PIR_ADDR,
		PIR_SUB,
		PIR_DATA,
		PIR_READ,
		PIR_IGNORE
	} pir_state_t;
	typedef struct packed {
		logic low_supply_flag;
		logic overheat_flag;
		logic [6:0] power_good;
	} pir_status_t;
	typedef struct packed {
		logic data_in;
		logic data_oe;
	} pir_sda_t;
endpackage

// file: pir_port.sv
// serial register port of the power-management device
// How it works
// - falling data with clock high restarts framing
// - rising data with clock high idles bus
// - eight bits msb first, then acknowledge clock
// - write acks address, sub-address and data
// - read acks address only, releases after byte
// - one byte per read, master ack ignored
// - acknowledge held low through clock high
// - option one answers address 0001001
// - option two answers address 0110100
// - write is address, sub-address, data
// - acknowledged data goes to holding latch
// - several sub-address/data pairs accepted per frame
// - holding latches survive repeated starts elsewhere
// - held data committed to registers at stop
// - sub-address 0Fh then 00h clears interrupt
// - upper sub-address nibble must be zero
// - read is sub-address write, restart, read
// - read after write returns that register
// - command and both status registers readable
// - step-down reset value 01101111
// - led current register resets to zero
// - masks let power-good faults pull outputs
// - bus-supply undervoltage clears port and registers
// - global reset restores defaults, regulators off
// - latched fault holds interrupt until clear
`timescale 1ns/1ps
`include "pir_params.svh"
module pir_port #(
	parameter bit ADDR_OPTION = 1'b0,
	parameter int OFF_CYCLES = `PIR_OFF_CYCLES
) (
	input wire logic SYS_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic BUS_SUPPLY_LOW_IN,
	input wire logic [6:0] POWER_GOOD_IN,
	input wire logic LOW_SUPPLY_FLAG_IN,
	input wire logic OVERHEAT_FLAG_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	output logic [87:0] CMD_REGS_OUT,
	output logic REGULATORS_OFF_OUT,
	output logic RESET_REQUEST_N_OUT,
	output logic INTERRUPT_N_OUT
);
	import pir_pkg::*;
	localparam logic [6:0] MY_ADDR = ADDR_OPTION ? `PIR_ADDR_OPT2 : `PIR_ADDR_OPT1;

	logic [1:0] scl_s_ff, sda_s_ff, sup_s_ff;
	logic scl_d_ff, sda_d_ff;
	logic [6:0] pg_s1_ff, pg_s2_ff;
	logic [1:0] flg_s1_ff, flg_s2_ff;
	logic scl, sda, rst_n, scl_rise, scl_fall, start_ev, stop_ev;
	pir_state_t state_ff;
	logic [3:0] bit_ff;
	logic [7:0] sh_ff;
	logic ack_ff;
	logic [7:0] sub_ff;
	logic [7:0] hold_ff [1:11];
	logic [7:0] cmd_ff [1:11];
	logic [11:1] dirty_ff;
	logic clr_armed_ff, clr_pending_ff, wrote_ff;
	logic [7:0] tx_ff;
	pir_status_t latch_ff;
	logic int_ff;
	logic [31:0] off_cnt_ff;
	logic [7:0] rd_byte;

	// pins are asynchronous to the system clock
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			scl_s_ff <= 2'h3;
			sda_s_ff <= 2'h3;
			sup_s_ff <= 2'h0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			pg_s1_ff <= 7'h7F;
			pg_s2_ff <= 7'h7F;
			flg_s1_ff <= 2'h0;
			flg_s2_ff <= 2'h0;
		end else begin
			scl_s_ff <= {scl_s_ff[0], SCL_IN};
			sda_s_ff <= {sda_s_ff[0], SDA_IN};
			sup_s_ff <= {sup_s_ff[0], BUS_SUPPLY_LOW_IN};
			scl_d_ff <= scl_s_ff[1];
			sda_d_ff <= sda_s_ff[1];
			pg_s1_ff <= POWER_GOOD_IN;
			pg_s2_ff <= pg_s1_ff;
			flg_s1_ff <= {LOW_SUPPLY_FLAG_IN, OVERHEAT_FLAG_IN};
			flg_s2_ff <= flg_s1_ff;
		end
	end

	assign scl = scl_s_ff[1];
	assign sda = sda_s_ff[1];
	assign rst_n = !sup_s_ff[1];
	assign scl_rise = scl && !scl_d_ff;
	assign scl_fall = !scl && scl_d_ff;
	assign start_ev = scl && scl_d_ff && sda_d_ff && !sda;
	assign stop_ev = scl && scl_d_ff && !sda_d_ff && sda;

	// read mux; unmapped or non-zero upper nibble gives zero
	always_comb begin
		rd_byte = 8'h00;
		if (sub_ff[7:4] == 4'h0) begin
			if (sub_ff[3:0] >= `PIR_SUB_SD1 && sub_ff[3:0] <= `PIR_SUB_IRQMASK) begin
				rd_byte = cmd_ff[sub_ff[3:0]];
			end else if (sub_ff[3:0] == `PIR_SUB_LIVE) begin
				rd_byte = {2'h0, pg_s2_ff[5:0]};
			end else if (sub_ff[3:0] == `PIR_SUB_LATCHED) begin
				rd_byte = {latch_ff.low_supply_flag, latch_ff.overheat_flag,
					latch_ff.power_good[5:0]};
			end
		end
	end

	// byte framing and protocol sequencing
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_ff <= PIR_IDLE;
			bit_ff <= 4'h0;
			sh_ff <= 8'h00;
			ack_ff <= 1'b0;
			sub_ff <= 8'h00;
			tx_ff <= 8'h00;
			SDA_OUT <= 1'b0;
			SDA_OE_OUT <= 1'b0;
		end else if (!rst_n) begin
			state_ff <= PIR_IDLE;
			bit_ff <= 4'h0;
			ack_ff <= 1'b0;
			sub_ff <= 8'h00;
			SDA_OE_OUT <= 1'b0;
		end else if (start_ev) begin
			state_ff <= PIR_ADDR;
			bit_ff <= 4'h0;
			ack_ff <= 1'b0;
			SDA_OE_OUT <= 1'b0;
		end else if (stop_ev) begin
			state_ff <= PIR_IDLE;
			bit_ff <= 4'h0;
			ack_ff <= 1'b0;
			SDA_OE_OUT <= 1'b0;
		end else if (state_ff != PIR_IDLE && state_ff != PIR_IGNORE) begin
			if (scl_rise && bit_ff < 4'h8 && state_ff != PIR_READ) begin
				sh_ff <= {sh_ff[6:0], sda};
			end
			if (scl_rise) begin
				bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
			end
			// drive changes only on the falling edge so data is stable with clock high
			if (scl_fall) begin
				if (bit_ff == 4'h8) begin
					ack_ff <= 1'b1;
					SDA_OE_OUT <= 1'b0;
					if (state_ff == PIR_ADDR) begin
						if (sh_ff[7:1] == MY_ADDR) begin
							SDA_OE_OUT <= 1'b1;
							SDA_OUT <= 1'b0;
						end
					end else if (state_ff != PIR_READ) begin
						SDA_OE_OUT <= 1'b1;
						SDA_OUT <= 1'b0;
					end
				end else if (ack_ff) begin
					ack_ff <= 1'b0;
					SDA_OE_OUT <= 1'b0;
					unique case (state_ff)
						PIR_ADDR: begin
							if (sh_ff[7:1] != MY_ADDR) begin
								state_ff <= PIR_IGNORE;
							end else if (sh_ff[0]) begin
								state_ff <= PIR_READ;
								tx_ff <= {rd_byte[6:0], 1'b0};
								SDA_OE_OUT <= !rd_byte[7];
								SDA_OUT <= 1'b0;
							end else begin
								state_ff <= PIR_SUB;
							end
						end
						PIR_SUB: begin
							sub_ff <= sh_ff;
							state_ff <= PIR_DATA;
						end
						PIR_DATA: state_ff <= PIR_SUB;
						PIR_READ: state_ff <= PIR_IGNORE;
						default: state_ff <= PIR_IGNORE;
					endcase
				end else if (state_ff == PIR_READ && bit_ff != 4'h0) begin
					// open-drain: a one is sent by releasing the line
					SDA_OE_OUT <= (bit_ff == 4'h8) ? 1'b0 : !tx_ff[7];
					SDA_OUT <= 1'b0;
					tx_ff <= {tx_ff[6:0], 1'b0};
				end
			end
		end
	end

	// holding latches, commit at stop, interrupt-clear sequence
	logic data_ack;
	assign data_ack = state_ff == PIR_DATA && scl_fall && bit_ff == 4'h8;

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			dirty_ff <= '0;
			clr_armed_ff <= 1'b0;
			clr_pending_ff <= 1'b0;
			wrote_ff <= 1'b0;
		end else if (!rst_n || REGULATORS_OFF_OUT) begin
			dirty_ff <= '0;
			clr_armed_ff <= 1'b0;
			clr_pending_ff <= 1'b0;
			wrote_ff <= 1'b0;
		end else if (stop_ev) begin
			dirty_ff <= '0;
			clr_pending_ff <= 1'b0;
			clr_armed_ff <= clr_pending_ff && !wrote_ff;
			wrote_ff <= 1'b0;
		end else begin
			if (data_ack && sub_ff[7:4] == 4'h0 && sub_ff[3:0] >= `PIR_SUB_SD1
					&& sub_ff[3:0] <= `PIR_SUB_IRQMASK) begin
				dirty_ff[sub_ff[3:0]] <= 1'b1;
			end
			// the clear command may arrive with or without a data byte
			if (state_ff == PIR_DATA && sub_ff == {4'h0, `PIR_SUB_CLR}) begin
				clr_pending_ff <= 1'b1;
			end
			// only an acknowledged data byte counts as a write; a bare pointer does not
			if (data_ack && sub_ff != {4'h0, `PIR_SUB_CLR}) begin
				wrote_ff <= 1'b1;
			end
		end
	end

	logic clear_cmd;
	assign clear_cmd = stop_ev && clr_armed_ff && !wrote_ff && !clr_pending_ff
		&& sub_ff == {4'h0, `PIR_SUB_NULL};

	logic global_rst;
	assign global_rst = cmd_ff[`PIR_SUB_ALARM][`PIR_GLOBAL_RESET_BIT];

	for (genvar i = 1; i <= `PIR_NUM_CMD; i++) begin : g_reg
		localparam logic [7:0] RST = (i <= 4) ? `PIR_RST_SD :
			(i == 8) ? `PIR_RST_LEDCUR :
			(i == 9) ? `PIR_RST_ALARM :
			(i == 10) ? `PIR_RST_RSTMASK :
			(i == 11) ? `PIR_RST_IRQMASK : `PIR_RST_UP;
		always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
			if (!RSTN_IN) begin
				hold_ff[i] <= RST;
				cmd_ff[i] <= RST;
			end else if (!rst_n || global_rst) begin
				hold_ff[i] <= RST;
				cmd_ff[i] <= RST;
			end else begin
				if (data_ack && sub_ff == 8'(i)) begin
					hold_ff[i] <= sh_ff;
				end
				if (stop_ev && dirty_ff[i]) begin
					cmd_ff[i] <= hold_ff[i];
				end
			end
		end
		assign CMD_REGS_OUT[8*i-1 -: 8] = cmd_ff[i];
	end

	// latched status and interrupt; set wins over clear
	logic pg_fault_irq, pg_fault_rst;
	assign pg_fault_irq = |(~pg_s2_ff & cmd_ff[`PIR_SUB_IRQMASK][6:0]);
	assign pg_fault_rst = |(~pg_s2_ff & cmd_ff[`PIR_SUB_RSTMASK][6:0]);

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			latch_ff <= '0;
			int_ff <= 1'b0;
		end else if (!rst_n) begin
			latch_ff <= '0;
			int_ff <= 1'b0;
		end else begin
			latch_ff <= (clear_cmd ? '0 : latch_ff)
				| {flg_s2_ff, ~pg_s2_ff};
			int_ff <= (int_ff && !clear_cmd) || pg_fault_irq || |flg_s2_ff;
		end
	end

	// global reset holds regulators off for the off time
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			off_cnt_ff <= '0;
			REGULATORS_OFF_OUT <= 1'b0;
			RESET_REQUEST_N_OUT <= 1'b0;
			INTERRUPT_N_OUT <= 1'b1;
		end else begin
			if (global_rst) begin
				off_cnt_ff <= 32'(OFF_CYCLES);
				REGULATORS_OFF_OUT <= 1'b1;
			end else if (off_cnt_ff != '0) begin
				off_cnt_ff <= off_cnt_ff - 32'h1;
				REGULATORS_OFF_OUT <= off_cnt_ff != 32'h1;
			end else begin
				REGULATORS_OFF_OUT <= 1'b0;
			end
			RESET_REQUEST_N_OUT <= !pg_fault_rst;
			INTERRUPT_N_OUT <= !int_ff;
		end
	end

	AST_START_FRAMES: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		start_ev && rst_n |=> state_ff == PIR_ADDR && bit_ff == 4'h0)
		else $error("start did not restart framing");
	AST_STOP_IDLES: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		stop_ev && !start_ev && rst_n |=> state_ff == PIR_IDLE)
		else $error("stop did not idle bus");
	AST_ACK_LOW: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		ack_ff && scl && (state_ff == PIR_SUB || state_ff == PIR_DATA) |-> SDA_OE_OUT && !SDA_OUT)
		else $error("acknowledge not low");
	AST_NO_READ_ACK: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		state_ff == PIR_READ && ack_ff |-> !SDA_OE_OUT)
		else $error("slave drove master acknowledge slot");
	AST_HOLD_UNTIL_STOP: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		!stop_ev && rst_n && !global_rst |=> $stable(cmd_ff[1]))
		else $error("command changed without stop");
	AST_COMMIT: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		stop_ev && dirty_ff[8] && rst_n && !global_rst |=> cmd_ff[8] == $past(hold_ff[8]))
		else $error("held data not committed");
	AST_INT_STICKY: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		int_ff && !clear_cmd && rst_n |=> int_ff)
		else $error("interrupt released without clear");
	AST_OFF_TIME: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		global_rst |=> REGULATORS_OFF_OUT [*8])
		else $error("regulators not held off");
endmodule // pir_port

// file: pir_bm.sv
// bus master model: drives the serial clock and data lines of the port
`timescale 1ns/1ps
module pir_bm (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	// clock stands high between frames, data released to the pull-up
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic q();
		repeat (2) @(posedge clk_in);
	endtask
	// one bus clock is 8 system cycles; sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_out <= b;
		q();
		scl_out <= 1'b1;
		q();
		r = sda_in;
		q();
		scl_out <= 1'b0;
		q();
	endtask
	// extra quarter lets the slave drop its ack before the clock rises
	task automatic start();
		sda_out <= 1'b1;
		q();
		q();
		scl_out <= 1'b1;
		q();
		sda_out <= 1'b0;
		q();
		scl_out <= 1'b0;
		q();
	endtask
	task automatic stop();
		sda_out <= 1'b0;
		q();
		scl_out <= 1'b1;
		q();
		sda_out <= 1'b1;
		q();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] d, output logic s);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(mack, s);
	endtask
endmodule // pir_bm

// file: pir_port_tb_top.sv
// self-checking bench for the serial register port
`timescale 1ns/1ps
`include "pir_params.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pir_port_tb_top;
	localparam int OFF_SIM = 50;
	localparam logic [87:0] DFLT = {`PIR_RST_IRQMASK, `PIR_RST_RSTMASK, `PIR_RST_ALARM,
		`PIR_RST_LEDCUR, `PIR_RST_LEDCFG, `PIR_RST_UP, `PIR_RST_UP, {4{`PIR_RST_SD}}};
	logic clk;
	logic rst_n;
	logic scl;
	logic sda_m;
	logic bus_low;
	logic [6:0] pg;
	logic low_flag;
	logic hot;
	logic sda_oe;
	logic [87:0] cmd;
	logic [87:0] cmd2;
	logic sda_o;
	logic sda_o2;
	logic sda_oe2;
	logic reg_off;
	logic rst_req_n;
	logic irq_n;
	logic ack;
	logic [7:0] rd;
	int num_errors = 0;
	int cmp_count = 0;
	// open drain with pull-up: low when the master or either port pulls
	wire sda = sda_m & (~sda_oe | sda_o) & (~sda_oe2 | sda_o2);
	pir_bm u_pir_bm (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
	pir_port #(.ADDR_OPTION(1'b0), .OFF_CYCLES(OFF_SIM)) u_pir_port (
		.SYS_CLK_IN(clk), .RSTN_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
		.BUS_SUPPLY_LOW_IN(bus_low), .POWER_GOOD_IN(pg), .LOW_SUPPLY_FLAG_IN(low_flag),
		.OVERHEAT_FLAG_IN(hot), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .CMD_REGS_OUT(cmd),
		.REGULATORS_OFF_OUT(reg_off), .RESET_REQUEST_N_OUT(rst_req_n),
		.INTERRUPT_N_OUT(irq_n));
	// second build option on the same bus answers its own address only
	pir_port #(.ADDR_OPTION(1'b1), .OFF_CYCLES(OFF_SIM)) u_pir_port_opt2 (
		.SYS_CLK_IN(clk), .RSTN_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
		.BUS_SUPPLY_LOW_IN(bus_low), .POWER_GOOD_IN(pg), .LOW_SUPPLY_FLAG_IN(low_flag),
		.OVERHEAT_FLAG_IN(hot), .SDA_OUT(sda_o2), .SDA_OE_OUT(sda_oe2), .CMD_REGS_OUT(cmd2),
		.REGULATORS_OFF_OUT(), .RESET_REQUEST_N_OUT(), .INTERRUPT_N_OUT());
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("compares=%0d mismatches=%0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] b);
		u_pir_bm.wbyte(b, ack);
		`CHK(ack, 1'b1)
	endtask
	task automatic wr_reg(input logic [7:0] sub, input logic [7:0] d);
		u_pir_bm.start();
		wr(8'h12);
		wr(sub);
		wr(d);
		u_pir_bm.stop();
		repeat (8) @(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] sub, input logic mack, input logic [7:0] e);
		logic s;
		u_pir_bm.start();
		wr(8'h12);
		wr(sub);
		u_pir_bm.start();
		wr(8'h13);
		u_pir_bm.rbyte(mack, rd, s);
		`CHK(s, mack)
		`CHK(rd, e)
		u_pir_bm.stop();
	endtask
	task automatic t_defaults();
		`CHK(cmd, DFLT)
		for (int i = 0; i < 11; i++) begin
			rd_reg(8'(i + 1), i[0], DFLT[8*i +: 8]);
		end
		$display("test defaults done");
	endtask
	task automatic t_write();
		u_pir_bm.start();
		wr(8'h12);
		wr(8'h01);
		wr(8'hA5);
		wr(8'h08);
		wr(8'hFF);
		`CHK(cmd, DFLT)
		u_pir_bm.stop();
		repeat (8) @(posedge clk);
		`CHK(cmd[7:0], 8'hA5)
		`CHK(cmd[63:56], 8'hFF)
		u_pir_bm.start();
		wr(8'h13);
		u_pir_bm.rbyte(1'b1, rd, ack);
		`CHK(rd, 8'hFF)
		u_pir_bm.stop();
		u_pir_bm.start();
		wr(8'h12);
		wr(8'h02);
		wr(8'h3C);
		u_pir_bm.start();
		wr(8'h68);
		wr(8'h01);
		wr(8'h5A);
		`CHK(cmd[15:8], `PIR_RST_SD)
		`CHK(cmd2[7:0], `PIR_RST_SD)
		u_pir_bm.stop();
		repeat (8) @(posedge clk);
		`CHK(cmd[15:8], 8'h3C)
		`CHK(cmd[7:0], 8'hA5)
		`CHK(cmd2[7:0], 8'h5A)
		u_pir_bm.start();
		wr(8'h69);
		u_pir_bm.rbyte(1'b0, rd, ack);
		`CHK(rd, 8'h5A)
		u_pir_bm.stop();
		$display("test write done");
	endtask
	task automatic t_refused();
		logic [87:0] snap;
		snap = cmd;
		wr_reg(8'h0C, 8'h55);
		wr_reg(8'h11, 8'h00);
		wr_reg(8'h0E, 8'h00);
		`CHK(cmd, snap)
		u_pir_bm.start();
		u_pir_bm.wbyte(8'h6A, ack);
		`CHK(ack, 1'b0)
		u_pir_bm.stop();
		rd_reg(8'h0E, 1'b0, 8'h00);
		rd_reg(8'h21, 1'b1, 8'h00);
		$display("test refused done");
	endtask
	task automatic t_irq();
		rd_reg(8'h0C, 1'b0, 8'h3F);
		pg <= 7'h7E;
		hot <= 1'b1;
		low_flag <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK(rst_req_n, 1'b0)
		pg <= 7'h7F;
		hot <= 1'b0;
		low_flag <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(rst_req_n, 1'b1)
		`CHK(irq_n, 1'b0)
		rd_reg(8'h0D, 1'b1, 8'hC1);
		wr_reg(8'h0F, 8'h00);
		`CHK(irq_n, 1'b0)
		u_pir_bm.start();
		wr(8'h12);
		wr(8'h00);
		u_pir_bm.stop();
		repeat (8) @(posedge clk);
		`CHK(irq_n, 1'b1)
		rd_reg(8'h0D, 1'b0, 8'h00);
		wr_reg(8'h0B, 8'h01);
		pg <= 7'h7E;
		repeat (8) @(posedge clk);
		pg <= 7'h7F;
		`CHK(irq_n, 1'b0)
		$display("test irq done");
	endtask
	task automatic t_resets();
		wr_reg(8'h09, 8'h80);
		`CHK(reg_off, 1'b1)
		`CHK(cmd, DFLT)
		repeat (OFF_SIM) @(posedge clk);
		`CHK(reg_off, 1'b0)
		wr_reg(8'h03, 8'h11);
		`CHK(cmd[23:16], 8'h11)
		bus_low <= 1'b1;
		repeat (6) @(posedge clk);
		bus_low <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(cmd, DFLT)
		rd_reg(8'h03, 1'b0, `PIR_RST_SD);
		$display("test resets done");
	endtask
	// a stuck bus would otherwise hang the run
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		rst_n = 1'b0;
		bus_low = 1'b0;
		pg = 7'h7F;
		low_flag = 1'b0;
		hot = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_defaults();
		t_write();
		t_refused();
		t_irq();
		t_resets();
		tally_and_finish();
	end
endmodule // pir_port_tb_top
